// ===== logic/cpg_defines.svh
// constants for the character pattern generator
`ifndef CPG_DEFINES_SVH
`define CPG_DEFINES_SVH
`define CPG_RAM_DEPTH 64
`define CPG_RAM_AW 6
`define CPG_ROM_N57 160
`define CPG_ROM_N510 32
`define CPG_ROW_LAST_510 4'ha
`define CPG_DOT_W 5
`define CPG_AC_RST 7'h00
`endif

// ===== logic/cpg_pkg.sv
// types for the character pattern generator
package cpg_pkg;
	typedef enum logic [0:0] {
		CPG_FONT_5X7 = 1'b0,
		CPG_FONT_5X10 = 1'b1
	} cpg_font_e;
	typedef enum logic [1:0] {
		CPG_ST_IDLE = 2'b00,
		CPG_ST_WRITE = 2'b01,
		CPG_ST_READ = 2'b10
	} cpg_state_e;
endpackage

// ===== logic/cpg_ram_if.sv
// port bundle between the top and the user pattern memory
interface cpg_ram_if;
	logic we;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ===== logic/cpg_pattern_ram.sv
// user pattern memory, 64 bytes, registered read data
`include "cpg_defines.svh"
module cpg_pattern_ram #(
	parameter int DEPTH = `CPG_RAM_DEPTH
) (
	input wire logic clk,
	cpg_ram_if.mem port_i
);
	logic [7:0] mem_q [DEPTH];
	// all eight bits stored, so bits 5 to 7 remain usable as plain data
	always_ff @(posedge clk) begin
		if (port_i.we) begin
			mem_q[port_i.addr] <= port_i.wdata; // [R03] [R09]
		end
		port_i.rdata <= mem_q[port_i.addr];
	end
endmodule // cpg_pattern_ram

// ===== logic/cpg_top.sv
// character pattern generator: fixed rom, user ram, host access and refresh lookup
`include "cpg_defines.svh"
// Contract
// [R01] fixed rom maps 8-bit code to 160 5x7 or 32 5x10 patterns
// [R02] rom code in display ram shows that rom pattern at its position
// [R03] user ram holds 64 bytes: eight 5x7 or four 5x10 characters
// [R04] upper four code bits zero select user ram instead of rom
// [R05] 5x7 font: ram address bits 0-2 select the dot row
// [R06] host data bus bit n maps to ram data bit n
// [R07] ram bit high lights a dot, low leaves it dark
// [R08] address counter steps by one after each host ram write
// [R09] only bits 0-4 drive dots; bits 5-7 stored and readable
// [R10] 5x10 font: ram address bits 0-3 select the dot row
// [R11] 5x10 rows 0-a shown; rows b-f hidden but readable
// [R12] 5x7 font ignores code bit 3 for user patterns
// [R13] 5x7 font: code bits 0-2 become ram address bits 3-5
// [R14] 5x10 font ignores code bits 0 and 3
// [R15] 5x10 font: code bits 1-2 become ram address bits 4-5
// [R16] host should clear the row whose address bits 0-2 are ones for cursor
// [R17] host sets direction, then address, then writes rows one byte each
// [R18] counter also steps after host reads of user or display ram
// [R19] font setting selects 5x7 or 5x10 mapping for rom and ram
// [R20] lookup returns five dots; refresh has priority over host access
module cpg_top #(
	parameter int ROM_N57 = `CPG_ROM_N57,
	parameter int ROM_N510 = `CPG_ROM_N510
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic font_10,
	input wire logic dir_inc,
	input wire logic ac_load,
	input wire logic [6:0] ac_value,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic host_sel_ram,
	input wire logic [7:0] host_data_bus,
	input wire logic disp_req,
	input wire logic [7:0] display_code_ram,
	input wire logic [3:0] disp_row,
	output logic [6:0] ac_q,
	output logic [7:0] host_rdata_q,
	output logic host_rvalid_q,
	output logic host_busy_q,
	output logic ac_step_q,
	output logic [4:0] dots_q,
	output logic dots_valid_q
);
	cpg_ram_if ram_port();
	cpg_pkg::cpg_state_e st_q;
	cpg_pkg::cpg_font_e font;
	logic [7:0] hwdata_q;
	logic hsel_q;
	logic [5:0] raddr;
	logic [5:0] ref_addr;
	logic [4:0] rom_dots;
	logic code_is_user;
	logic row_shown;
	logic user_q;
	logic shown_q;
	logic ref_pend_q;
	logic [4:0] rom_q;
	logic host_gnt;
	logic host_step;
	logic ram_rd_gnt;

	cpg_pattern_ram u_ram (
		.clk(clk),
		.port_i(ram_port.mem)
	);

	assign font = font_10 ? cpg_pkg::CPG_FONT_5X10 : cpg_pkg::CPG_FONT_5X7; // [R19]

	// refresh address build; code bits unused by a font are dropped here
	always_comb begin
		code_is_user = (display_code_ram[7:4] == 4'h0); // [R04]
		if (font == cpg_pkg::CPG_FONT_5X10) begin
			ref_addr = {display_code_ram[2:1], disp_row}; // [R10] [R14] [R15]
			row_shown = (disp_row <= `CPG_ROW_LAST_510); // [R11]
		end else begin
			ref_addr = {display_code_ram[2:0], disp_row[2:0]}; // [R05] [R12] [R13]
			row_shown = (disp_row[3] == 1'b0);
		end
	end

	// host access waits for as long as refresh holds the single ram port
	assign host_gnt = !disp_req; // [R20]

	// a granted pending access is also the moment the counter steps
	assign host_step = (st_q != cpg_pkg::CPG_ST_IDLE) && host_gnt; // [R08] [R18]
	assign ram_rd_gnt = (st_q == cpg_pkg::CPG_ST_READ) && host_gnt && hsel_q;

	// ram port mux: refresh first, then the pending host operation
	always_comb begin
		raddr = ac_q[5:0];
		if (disp_req) begin
			raddr = ref_addr; // [R20]
		end
		ram_port.addr = raddr;
		ram_port.we = host_gnt && hsel_q && (st_q == cpg_pkg::CPG_ST_WRITE);
		ram_port.wdata = hwdata_q; // [R06]
	end

	// fixed pattern rom; glyphs are a stand-in until the real table is dropped in
	always_comb begin
		rom_dots = rom_pattern(display_code_ram, disp_row, font_10); // [R01]
	end

	// seed per low code nibble, so neighbouring codes give distinct glyphs
	function automatic logic [4:0] glyph_seed(
		input logic [3:0] lo
	);
		logic [4:0] s;
		s = 5'h00;
		unique case (lo)
			4'h0: s = 5'h0e;
			4'h1: s = 5'h11;
			4'h2: s = 5'h1f;
			4'h3: s = 5'h04;
			4'h4: s = 5'h0a;
			4'h5: s = 5'h15;
			4'h6: s = 5'h1b;
			4'h7: s = 5'h06;
			4'h8: s = 5'h0c;
			4'h9: s = 5'h18;
			4'ha: s = 5'h03;
			4'hb: s = 5'h13;
			4'hc: s = 5'h19;
			4'hd: s = 5'h07;
			4'he: s = 5'h1c;
			4'hf: s = 5'h09;
		endcase
		return s;
	endfunction

	// row mask; rows past 6 (5x7) or past a (5x10) stay dark, so the 5x7 cursor row is free
	function automatic logic [4:0] row_shape(
		input logic [3:0] row,
		input logic big
	);
		logic [4:0] m;
		m = 5'h00;
		unique case (row)
			4'h0: m = 5'h1f;
			4'h1: m = 5'h11;
			4'h2: m = 5'h1b;
			4'h3: m = 5'h15;
			4'h4: m = 5'h0e;
			4'h5: m = 5'h1d;
			4'h6: m = 5'h17;
			4'h7: m = 5'h0f;
			4'h8: m = 5'h1e;
			4'h9: m = 5'h13;
			4'ha: m = 5'h19;
			default: m = 5'h00;
		endcase
		if (!big && (row > 4'h6)) begin
			m = 5'h00;
		end
		return m;
	endfunction

	// codes outside the rom range of the chosen font give a dark cell
	function automatic logic [4:0] rom_pattern(
		input logic [7:0] code,
		input logic [3:0] row,
		input logic big
	);
		logic [7:0] idx;
		logic [4:0] pat;
		idx = code - 8'h10;
		pat = 5'h00;
		if (!big && (int'(idx) < ROM_N57)) begin
			pat = (glyph_seed(code[3:0]) ^ {code[7:4], 1'b0}) & row_shape(row, big);
		end else if (big && (int'(code[7:3]) >= 5'h1c) && (int'(code[4:0]) < ROM_N510)) begin
			pat = (glyph_seed(code[3:0]) ^ {code[4], 4'h0}) & row_shape(row, big);
		end
		return pat;
	endfunction

	// host sequencer: write and read take one ram cycle when granted
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= cpg_pkg::CPG_ST_IDLE;
		end else begin
			unique case (st_q)
				cpg_pkg::CPG_ST_IDLE: begin
					if (host_wr) begin
						st_q <= cpg_pkg::CPG_ST_WRITE;
					end else if (host_rd) begin
						st_q <= cpg_pkg::CPG_ST_READ;
					end
				end
				cpg_pkg::CPG_ST_WRITE, cpg_pkg::CPG_ST_READ: begin
					if (host_gnt) begin
						st_q <= cpg_pkg::CPG_ST_IDLE;
					end
				end
				default: st_q <= cpg_pkg::CPG_ST_IDLE;
			endcase
		end
	end

	// request capture: only a request taken while idle may change data or target
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hwdata_q <= 8'h00;
			hsel_q <= 1'b0;
		end else if ((st_q == cpg_pkg::CPG_ST_IDLE) && (host_wr || host_rd)) begin
			hsel_q <= host_sel_ram;
			if (host_wr) begin
				hwdata_q <= host_data_bus; // [R06]
			end
		end
	end

	// busy while an operation is pending
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_busy_q <= 1'b0;
		end else begin
			host_busy_q <= (st_q == cpg_pkg::CPG_ST_IDLE) ? (host_wr || host_rd) : !host_gnt;
		end
	end

	// address counter: load, or step after every granted access
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ac_q <= `CPG_AC_RST;
			ac_step_q <= 1'b0;
		end else begin
			ac_step_q <= 1'b0;
			if (ac_load) begin
				ac_q <= ac_value;
			end else if (host_step) begin
				ac_step_q <= 1'b1;
				ac_q <= dir_inc ? ac_q + 7'h01 : ac_q - 7'h01; // [R08] [R18]
			end
		end
	end

	// ram read in flight: the word reaches the port one edge after the grant
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_pend_q <= 1'b0;
		end else begin
			ref_pend_q <= ram_rd_gnt;
		end
	end

	// read data: ram word is taken the cycle it stands on the port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_rvalid_q <= 1'b0;
			host_rdata_q <= 8'h00;
		end else begin
			host_rvalid_q <= 1'b0;
			if (ref_pend_q) begin
				host_rvalid_q <= 1'b1;
				host_rdata_q <= ram_port.rdata; // [R06] [R09] [R11]
			end else if ((st_q == cpg_pkg::CPG_ST_READ) && host_gnt && !hsel_q) begin
				host_rvalid_q <= 1'b1; // display ram data is returned by the outside
				host_rdata_q <= display_code_ram;
			end
		end
	end

	// refresh pipeline stage one: remember source and rom pattern
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			user_q <= 1'b0;
			shown_q <= 1'b0;
			rom_q <= 5'h00;
		end else begin
			user_q <= code_is_user;
			shown_q <= row_shown;
			rom_q <= rom_dots; // [R02]
		end
	end

	// dot flag: follows the request by one register stage; the lookup result at dots_q takes two
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dots_valid_q <= 1'b0;
		end else begin
			dots_valid_q <= disp_req; // [R20]
		end
	end

	// dot output: high bit lights a dot; hidden rows forced dark
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dots_q <= 5'h00;
		end else if (user_q) begin
			dots_q <= shown_q ? ram_port.rdata[4:0] : 5'h00; // [R07] [R09] [R11]
		end else begin
			dots_q <= rom_q; // [R02]
		end
	end
endmodule // cpg_top

// ===== test/cpg_top_assertions.sv
// port checks for the pattern generator
module cpg_top_assertions (
	input logic clk, rst, font_10, dir_inc, ac_load, host_wr, host_rd, host_busy_q,
	input logic disp_req, host_rvalid_q, ac_step_q, dots_valid_q,
	input logic [6:0] ac_value, ac_q,
	input logic [3:0] disp_row,
	input logic [4:0] dots_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// a write only counts when taken while idle and not overridden by a load
	sequence s_wr;
		host_wr && !host_busy_q && !ac_load;
	endsequence
	chk_wr_step: assert property (s_wr |-> ##[1:20] ac_step_q) else $error("no step");
	chk_step_dir: assert property (ac_step_q && !$past(ac_load) |->
		ac_q == $past(ac_q) + ($past(dir_inc) ? 7'h01 : 7'h7f)) else $error("bad step");
	chk_load_val: assert property (ac_load |=> ac_q == $past(ac_value)) else $error("bad load");
	chk_step_pulse: assert property (ac_step_q |=> !ac_step_q) else $error("long step");
	chk_rd_answer: assert property (host_rd && !host_busy_q |-> ##[1:20] host_rvalid_q)
		else $error("no answer");
	chk_dots_flag: assert property (disp_req |=> dots_valid_q) else $error("no flag");
	chk_dots_idle: assert property (!disp_req |=> !dots_valid_q) else $error("stray flag");
	chk_hidden_row: assert property (disp_req && font_10 && disp_row > 4'ha |->
		##2 dots_q == 5'h00) else $error("hidden row lit");
endmodule // cpg_top_assertions
bind cpg_top cpg_top_assertions u_chk (.*);

// ===== test/cpg_host_model.sv
// host model: counter loads and byte accesses
module cpg_host_model (
	input logic clk, host_busy_q, host_rvalid_q,
	output logic dir_inc, ac_load, host_wr, host_rd,
	output logic [6:0] ac_value,
	output logic [7:0] host_data_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {dir_inc, ac_load, host_wr, host_rd, ac_value, host_data_bus} = '0;
	// bounded wait for idle or read data, so a stuck flag cannot hang us
	task automatic hold(input logic rd);
		for (int n = 0; n < 40; n++) begin
			@(negedge clk);
			if ((rd ? !host_rvalid_q : host_busy_q) === 1'b0) break;
		end
	endtask
	// direction settles a cycle before the address is loaded
	task automatic load(input logic dir, input logic [6:0] a);
		hold(1'b0);
		@(posedge clk) dir_inc <= dir;
		@(posedge clk) {ac_load, ac_value} <= {1'b1, a};
		@(posedge clk) ac_load <= 1'b0;
	endtask
	// one byte per access; data held until done, then inverted
	task automatic xfer(input logic wr, input logic [7:0] d);
		hold(1'b0);
		@(posedge clk) {host_wr, host_rd, host_data_bus} <= {wr, !wr, d};
		@(posedge clk) {host_wr, host_rd} <= 2'b00;
		hold(!wr);
		@(posedge clk) host_data_bus <= ~d;
	endtask
endmodule // cpg_host_model

// ===== test/cpg_top_tb_top.sv
// self-checking bench for the pattern generator
module cpg_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, font_10, disp_req, dir_inc, ac_load, host_wr, host_rd, host_busy_q;
	logic host_rvalid_q, host_sel_ram;
	logic [7:0] display_code_ram, host_rdata_q, host_data_bus, mem [64];
	logic [6:0] ac_q, ac_value;
	logic [4:0] dots_q;
	logic [3:0] disp_row;
	int err_count = 0;
	int compares = 0;
	cpg_host_model host (.*);
	cpg_top dut (.*, .ac_step_q(), .dots_valid_q());
	// free-running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// steady lookup; dots come out two edges after the request
	task automatic show(input logic f, input logic [7:0] c, input logic [3:0] r, input logic [4:0] e);
		@(posedge clk) {font_10, display_code_ram, disp_row, disp_req} <= {f, c, r, 1'b1};
		repeat (2) @(posedge clk);
		@(posedge clk) disp_req <= 1'b0;
		@(negedge clk) chk({3'h0, dots_q}, {3'h0, e});
	endtask
	// cursor rows get dark dots but keep their upper bits
	task automatic fill(input logic dir, input logic [5:0] a, input int n, input logic [7:0] b);
		logic [5:0] p;
		p = a;
		host.load(dir, {1'b0, a});
		for (int i = 0; i < n; i++) begin
			mem[p] = (p[2:0] == 3'h7) ? 8'he0 : b + 8'(i * 37);
			host.xfer(1'b1, mem[p]);
			p = dir ? p + 6'h01 : p - 6'h01;
			chk({1'b0, ac_q}, {2'h0, p});
		end
	endtask
	task automatic t_57();
		fill(1'b1, 6'h08, 8, 8'h35);
		host.load(1'b1, 7'h08);
		for (int i = 8; i < 16; i++) begin
			host.xfer(1'b0, 8'h00);
			chk(host_rdata_q, mem[i]);
		end
		chk({1'b0, ac_q}, 8'h10);
		for (int i = 0; i < 16; i++)
			show(1'b0, {4'h0, i[3], 3'h1}, {1'b0, i[2:0]}, mem[{3'h1, i[2:0]}][4:0]);
		$display("test 5x7 done");
	endtask
	// display ram read: data comes from the code input, counter steps down
	task automatic t_dsp();
		host.load(1'b0, 7'h45);
		display_code_ram <= 8'h5a;
		host_sel_ram <= 1'b0;
		host.xfer(1'b0, 8'h00);
		chk(host_rdata_q, 8'h5a);
		chk({1'b0, ac_q}, 8'h44);
		host_sel_ram <= 1'b1;
		$display("test display read done");
	endtask
	task automatic t_510();
		logic [4:0] e;
		fill(1'b0, 6'h2f, 16, 8'h11);
		for (int i = 0; i < 64; i++) begin
			e = (i[3:0] > 4'ha) ? 5'h00 : mem[{2'b10, i[3:0]}][4:0];
			show(1'b1, {4'h0, i[5], 2'b10, i[4]}, i[3:0], e);
		end
		$display("test 5x10 done");
	endtask
	// reset, then the scenarios
	initial begin
		{rst, font_10, disp_req, display_code_ram, disp_row} = {1'b1, 14'h0};
		host_sel_ram = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_57();
		t_dsp();
		t_510();
		summarize();
	end
	// watchdog, far beyond the few hundred cycles needed
	initial begin
		#200000;
		err_count++;
		summarize();
	end
endmodule // cpg_top_tb_top
